// File: pkg/lfm_defs.vh
/*
  Shared constants for the loop fail monitor and display block.
  Assumes a 125 MHz controller clock and inclusion by bare name.
*/
`ifndef LFM_DEFS_VH
`define LFM_DEFS_VH

// Register byte offsets
`define LFM_REG_CTRL 4'h0
`define LFM_REG_MEAS0 4'h4
`define LFM_REG_MEAS1 4'h8
`define LFM_REG_STAT 4'hC
// CTRL fields
`define LFM_CTRL_SCREEN_LSB 0
`define LFM_CTRL_PCT_OPT 3
`define LFM_CTRL_TRAIN 4
`define LFM_CTRL_PRESENCE 5
`define LFM_CTRL_SENS_LSB 8
`define LFM_CTRL_SENS0_LSB 8
`define LFM_CTRL_SENS1_LSB 12
`define LFM_CTRL_RST 32'h00000000
// Screens
`define LFM_SCR_NORMAL 3'h0
`define LFM_SCR_PCT 3'h1
`define LFM_SCR_COUNT 3'h2
`define LFM_SCR_TEST 3'h3
`define LFM_SCR_FAILCNT 3'h4
// Limits, change in 1/100 percent units, signed; the count limit is unsigned
`define LFM_STEP_LIMIT 16'sd2500
`define LFM_SENS2_THRESH 16'sd32
`define LFM_CNT_MAX 8'hFF
// Fault codes on the seven segment field
`define LFM_CODE_NONE 2'h0
`define LFM_CODE_LOW 2'h1
`define LFM_CODE_HIGH 2'h2
// Flash timing
`define LFM_CLK_HZ 125000000
`define LFM_ALERT_MS 333
`define LFM_ALERT_CYC (`LFM_CLK_HZ / 1000 * `LFM_ALERT_MS)
`define LFM_FLASH_MS 500
`define LFM_FLASH_CYC (`LFM_CLK_HZ / 1000 * `LFM_FLASH_MS)
`define LFM_ALT_MS 1000
`define LFM_ALT_CYC (`LFM_CLK_HZ / 1000 * `LFM_ALT_MS)

`endif

// File: hw/lfm_top.v
/*
  Two-channel loop fail supervision, call forcing, alert LED, fault counter
  and display screen selection, with an Avalon-MM register slave.
  Assumes loop measurements and buttons arrive asynchronously from outside.
*/
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "lfm_defs.vh"

module lfm_top
(
  input wire MCLK,
  input wire ARST_N,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire [1:0] LOOP_SHORT,
  input wire [1:0] LOOP_OPEN,
  input wire [1:0] VEHICLE,
  input wire [1:0] TIMING,
  input wire [1:0] DETECT_CALL,
  input wire MAN_RESET_0,
  input wire MAN_RESET_1,
  input wire BTN_UP,
  input wire BTN_DOWN,
  input wire FUNCTION_STEP_BUTTON,
  input wire DISP_CH,
  output reg [1:0] CALL_OUT,
  output reg [1:0] LED,
  output reg [1:0] LOOP_FAIL_MSG,
  output reg [1:0] FAULT_CODE_0,
  output reg [1:0] FAULT_CODE_1,
  output reg [7:0] BARGRAPH,
  output reg [16:0] SEG_VALUE,
  output reg [2:0] SEG_SEL,
  output reg SEG_BLANK,
  output reg SEG_ALL_ON,
  output reg TEXT_ALL_ON,
  output reg [2:0] SCREEN
);

  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_PCT = 3'h1;
  localparam [2:0] SEL_CNT_LO = 3'h2;
  localparam [2:0] SEL_CNT_HI = 3'h3;
  localparam [2:0] SEL_FAIL = 3'h4;
  localparam [2:0] SEL_FCNT = 3'h5;

  // Two-flop synchronisers for the fault, vehicle, timing and button pins; DETECT_CALL and DISP_CH are not synchronised
  reg [11:0] sync_a;
  reg [11:0] sync_b;
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sync_a <= 12'h000;
      sync_b <= 12'h000;
    end
    else
    begin
      sync_a <= {LOOP_SHORT, LOOP_OPEN, VEHICLE, TIMING, MAN_RESET_1, MAN_RESET_0,
                 BTN_UP | BTN_DOWN, FUNCTION_STEP_BUTTON};
      sync_b <= sync_a;
    end
  end
  wire [1:0] s_short = sync_b[11:10];
  wire [1:0] s_open = sync_b[9:8];
  wire [1:0] s_veh = sync_b[7:6];
  wire [1:0] s_tim = sync_b[5:4];
  wire [1:0] s_mrst = sync_b[3:2];
  wire s_updn = sync_b[1];
  wire s_step = sync_b[0];

  // Registers
  reg [31:0] ctrl;
  reg [31:0] meas0;
  reg [31:0] meas1;
  reg [1:0] meas_new;
  reg ack;
  wire req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  wire bus_wr = AVS_WRITE & ack;

  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ack <= 1'b0;
      ctrl <= `LFM_CTRL_RST;
      meas0 <= 32'h00000000;
      meas1 <= 32'h00000000;
      meas_new <= 2'h0;
    end
    else
    begin
      ack <= req & ~ack;
      meas_new <= 2'h0;
      if (bus_wr && AVS_ADDRESS == `LFM_REG_CTRL)
        ctrl <= AVS_WRITEDATA;
      if (bus_wr && AVS_ADDRESS == `LFM_REG_MEAS0)
      begin
        meas0 <= AVS_WRITEDATA;
        meas_new[0] <= 1'b1;
      end
      if (bus_wr && AVS_ADDRESS == `LFM_REG_MEAS1)
      begin
        meas1 <= AVS_WRITEDATA;
        meas_new[1] <= 1'b1;
      end
    end
  end

  // MEASn: [15:0] signed change since last sample, [31:16] signed change
  // from reference, both in 1/100 percent; negative means vehicle loading.
  function [15:0] absval;
    input [15:0] v;
    begin
      absval = v[15] ? (16'h0000 - v) : v;
    end
  endfunction

  // thresholds double per level, so shifts replace a table
  function [7:0] bars;
    input [15:0] dl;
    input [3:0] sens;
    reg [15:0] mag;
    integer k;
    begin
      mag = dl[15] ? (16'h0000 - dl) : 16'h0000;
      bars = 8'h00;
      // level two sits at 32 hundredths, doubling per lower level
      for (k = 0; k < 8; k = k + 1)
        if (sens >= k[3:0] + 4'h1 &&
            mag >= (16'd32 << ((sens - k[3:0] > 4'h2) ? 4'h0 : (4'h2 - (sens - k[3:0]))))
                   >> ((sens - k[3:0] > 4'h2) ? (sens - k[3:0] - 4'h2) : 4'h0))
          bars[k] = 1'b1;
    end
  endfunction

  // Per-channel fault state
  reg [1:0] fail;
  reg [1:0] fail_low;
  reg [1:0] alert;
  reg [7:0] fail_cnt0;
  reg [7:0] fail_cnt1;
  reg step_d;
  reg updn_d;
  reg [2:0] function_step_button_pos;
  wire [1:0] step_hi;
  wire [1:0] step_lo;
  assign step_hi[0] = ~meas0[15] && meas_new[0] && meas0[15:0] > `LFM_STEP_LIMIT;
  assign step_lo[0] = meas0[15] && meas_new[0] && absval(meas0[15:0]) > `LFM_STEP_LIMIT;
  assign step_hi[1] = ~meas1[15] && meas_new[1] && meas1[15:0] > `LFM_STEP_LIMIT;
  assign step_lo[1] = meas1[15] && meas_new[1] && absval(meas1[15:0]) > `LFM_STEP_LIMIT;
  wire [1:0] new_low = s_short | step_lo;
  wire [1:0] new_high = s_open | step_hi;
  wire [1:0] fault_start = (new_low | new_high) & ~fail;
  wire [1:0] heal = fail & ~s_short & ~s_open & ~step_lo & ~step_hi & meas_new;
  wire clr_req = s_updn & ~updn_d && function_step_button_pos == `LFM_SCR_FAILCNT;

  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      fail <= 2'h0;
      fail_low <= 2'h0;
      alert <= 2'h0;
      fail_cnt0 <= 8'h00;
      fail_cnt1 <= 8'h00;
      step_d <= 1'b0;
      updn_d <= 1'b0;
      function_step_button_pos <= `LFM_SCR_NORMAL;
    end
    else
    begin
      step_d <= s_step;
      updn_d <= s_updn;
      if (s_step && !step_d)
        function_step_button_pos <= (function_step_button_pos == `LFM_SCR_FAILCNT) ? `LFM_SCR_NORMAL : function_step_button_pos + 3'h1;
      // range loss or big step enters fail-safe; code kept while faulty
      fail <= (fail | new_low | new_high) & ~heal & ~s_mrst;
      fail_low <= (fail_low & ~fault_start & fail) | (fault_start & new_low);
      // alert starts on fault, only manual reset or clear ends it
      // clear by count reset; set wins over clear
      alert <= (alert & ~s_mrst & ~({clr_req & DISP_CH, clr_req & ~DISP_CH})) | fault_start;
      // count each failure; saturates; clear loses to a new fault
      // A fault that meets a clear at saturation must still not lose the count
      if (fault_start[0])
      begin
        if (fail_cnt0 != `LFM_CNT_MAX)
          fail_cnt0 <= fail_cnt0 + 8'h01;
      end
      else if (s_mrst[0] || (clr_req && !DISP_CH))
        fail_cnt0 <= 8'h00;
      if (fault_start[1])
      begin
        if (fail_cnt1 != `LFM_CNT_MAX)
          fail_cnt1 <= fail_cnt1 + 8'h01;
      end
      else if (s_mrst[1] || (clr_req && DISP_CH))
        fail_cnt1 <= 8'h00;
    end
  end

  // Flash timers; shared so both channels blink in step
  reg [25:0] alert_tmr;
  reg [25:0] flash_tmr;
  reg [26:0] alt_tmr;
  reg alert_ph;
  reg flash_ph;
  reg alt_ph;
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      alert_tmr <= 26'h0000000;
      flash_tmr <= 26'h0000000;
      alt_tmr <= 27'h0000000;
      alert_ph <= 1'b0;
      flash_ph <= 1'b0;
      alt_ph <= 1'b0;
    end
    else
    begin
      // half period of a three per second flash
      if (alert_tmr >= (`LFM_ALERT_CYC / 2) - 1)
      begin
        alert_tmr <= 26'h0000000;
        alert_ph <= ~alert_ph;
      end
      else
        alert_tmr <= alert_tmr + 26'h0000001;
      if (flash_tmr >= `LFM_FLASH_CYC - 1)
      begin
        flash_tmr <= 26'h0000000;
        flash_ph <= ~flash_ph;
      end
      else
        flash_tmr <= flash_tmr + 26'h0000001;
      if (alt_tmr >= `LFM_ALT_CYC - 1)
      begin
        alt_tmr <= 27'h0000000;
        alt_ph <= ~alt_ph;
      end
      else
        alt_tmr <= alt_tmr + 27'h0000001;
    end
  end

  // Channel outputs and display
  wire [2:0] scr_sel = ctrl[2:0];
  wire [31:0] cm = DISP_CH ? meas1 : meas0;
  wire [3:0] sens = DISP_CH ? ctrl[15:12] : ctrl[11:8];
  wire veh = DISP_CH ? s_veh[1] : s_veh[0];
  wire tim = DISP_CH ? s_tim[1] : s_tim[0];
  wire cfail = DISP_CH ? fail[1] : fail[0];
  wire clow = DISP_CH ? fail_low[1] : fail_low[0];
  wire [16:0] vcount = {ctrl[31:16], 1'b0};
  // decimal split; counts past 99999 show a third upper digit
  wire [16:0] cnt_div = vcount / 17'h003E8;
  wire [7:0] cnt_hi = cnt_div[7:0];
  wire [16:0] cnt_lo = vcount % 17'h003E8;
  reg [1:0] next_call;
  reg [1:0] next_led;
  reg [7:0] next_bar;
  reg [16:0] next_val;
  reg [2:0] next_sel;
  reg next_blank;
  reg [2:0] next_scr;

  always @*
  begin
    // fail-safe call regardless of presence or pulse mode
    next_call = DETECT_CALL | fail;
    // alert overrides LED even after self-heal
    next_led = (DETECT_CALL & ~alert) | (alert & {alert_ph, alert_ph});
    next_scr = (function_step_button_pos == `LFM_SCR_FAILCNT) ? `LFM_SCR_FAILCNT : scr_sel;
    next_bar = 8'h00;
    next_val = 17'h00000;
    next_sel = SEL_NONE;
    next_blank = 1'b0;
    if (cfail)
      next_sel = SEL_FAIL;
    else
      case (next_scr)
        `LFM_SCR_PCT:
        begin
          // only while detecting and untimed; bargraph stays off
          if (ctrl[`LFM_CTRL_PCT_OPT] && veh && !tim)
          begin
            next_val = {1'b0, absval(cm[31:16])};
            next_sel = SEL_PCT;
          end
          else
            next_bar = veh ? bars(cm[31:16], sens) : 8'h00;
        end
        `LFM_SCR_COUNT:
        begin
          next_bar = veh ? bars(cm[31:16], sens) : 8'h00;
          if (cnt_hi != 8'h00 && alt_ph)
          begin
            next_val = {9'h000, cnt_hi};
            next_sel = SEL_CNT_HI;
          end
          else
          begin
            next_val = cnt_lo;
            next_sel = SEL_CNT_LO;
          end
          next_blank = ctrl[`LFM_CTRL_TRAIN] & flash_ph;
        end
        `LFM_SCR_FAILCNT:
        begin
          next_val = {9'h000, DISP_CH ? fail_cnt1 : fail_cnt0};
          next_sel = SEL_FCNT;
        end
        default:
          next_bar = veh ? bars(cm[31:16], sens) : 8'h00;
      endcase
    // test lights everything, call path above untouched
    if (next_scr == `LFM_SCR_TEST)
    begin
      next_bar = 8'hFF;
      next_blank = 1'b0;
    end
  end

  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      CALL_OUT <= 2'h0;
      LED <= 2'h0;
      LOOP_FAIL_MSG <= 2'h0;
      FAULT_CODE_0 <= `LFM_CODE_NONE;
      FAULT_CODE_1 <= `LFM_CODE_NONE;
      BARGRAPH <= 8'h00;
      SEG_VALUE <= 17'h00000;
      SEG_SEL <= SEL_NONE;
      SEG_BLANK <= 1'b0;
      SEG_ALL_ON <= 1'b0;
      TEXT_ALL_ON <= 1'b0;
      SCREEN <= `LFM_SCR_NORMAL;
      AVS_READDATA <= 32'h00000000;
    end
    else
    begin
      CALL_OUT <= next_call;
      LED <= next_led;
      LOOP_FAIL_MSG <= fail;
      // low for short or negative step, high for open or positive step
      FAULT_CODE_0 <= !fail[0] ? `LFM_CODE_NONE : fail_low[0] ? `LFM_CODE_LOW : `LFM_CODE_HIGH;
      FAULT_CODE_1 <= !fail[1] ? `LFM_CODE_NONE : fail_low[1] ? `LFM_CODE_LOW : `LFM_CODE_HIGH;
      BARGRAPH <= next_bar;
      SEG_VALUE <= next_val;
      SEG_SEL <= next_sel;
      SEG_BLANK <= next_blank;
      SEG_ALL_ON <= next_scr == `LFM_SCR_TEST;
      TEXT_ALL_ON <= next_scr == `LFM_SCR_TEST;
      SCREEN <= next_scr;
      if (AVS_READ && !ack)
        case (AVS_ADDRESS)
          `LFM_REG_CTRL: AVS_READDATA <= ctrl;
          `LFM_REG_MEAS0: AVS_READDATA <= meas0;
          `LFM_REG_MEAS1: AVS_READDATA <= meas1;
          `LFM_REG_STAT: AVS_READDATA <= {fail_cnt1, fail_cnt0, 7'h00, function_step_button_pos,
                                          alert, fail_low, fail};
          default: AVS_READDATA <= 32'h00000000;
        endcase
    end
  end

endmodule
`default_nettype wire

// File: sim/lfm_asserts.sv
/*
  Port checker for the loop fail block.
  Assumes a bind from the bench top file.
*/
`timescale 1ns/10ps
`default_nettype none
module lfm_asserts
(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic [1:0] LOOP_SHORT,
  input wire logic [1:0] LOOP_OPEN,
  input wire logic [1:0] VEHICLE,
  input wire logic [1:0] DETECT_CALL,
  input wire logic [1:0] CALL_OUT,
  input wire logic [1:0] LOOP_FAIL_MSG,
  input wire logic [1:0] FAULT_CODE_0,
  input wire logic [1:0] FAULT_CODE_1,
  input wire logic [7:0] BARGRAPH,
  input wire logic [2:0] SEG_SEL,
  input wire logic SEG_ALL_ON,
  input wire logic TEXT_ALL_ON,
  input wire logic [2:0] SCREEN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  a_call_fail0: assert property (LOOP_FAIL_MSG[0] && $past(LOOP_FAIL_MSG[0]) |-> CALL_OUT[0])
    else $error("call not forced on channel 0");
  a_call_fail1: assert property (LOOP_FAIL_MSG[1] && $past(LOOP_FAIL_MSG[1]) |-> CALL_OUT[1])
    else $error("call not forced on channel 1");
  a_short_low: assert property ($rose(LOOP_SHORT[0]) |-> ##[1:6] (LOOP_FAIL_MSG[0] && FAULT_CODE_0 == 2'h1))
    else $error("short loop not shown as low fault");
  a_open_high: assert property ($rose(LOOP_OPEN[1]) |-> ##[1:6] (LOOP_FAIL_MSG[1] && FAULT_CODE_1 == 2'h2))
    else $error("open loop not shown as high fault");
  a_code_held: assert property (LOOP_FAIL_MSG[1] |-> FAULT_CODE_1 != 2'h0)
    else $error("fault code missing during fail");
  a_test_lit: assert property (SCREEN == 3'h3 && $past(SCREEN) == 3'h3 |-> SEG_ALL_ON && TEXT_ALL_ON && BARGRAPH == 8'hFF)
    else $error("display test not fully lit");
  a_test_call: assert property (SCREEN == 3'h3 && !LOOP_FAIL_MSG[0] && !$past(LOOP_FAIL_MSG[0]) |-> CALL_OUT[0] == $past(DETECT_CALL[0]))
    else $error("call disturbed by display test");
  a_pct_dark: assert property (SEG_SEL == 3'h1 |-> BARGRAPH == 8'h00 && SCREEN == 3'h1)
    else $error("bargraph lit on percent screen");
  a_count_dark: assert property (SCREEN == 3'h2 && $past(SCREEN) == 3'h2 && $past(VEHICLE, 3) == 2'h0 && $past(VEHICLE, 4) == 2'h0 |-> BARGRAPH == 8'h00)
    else $error("bargraph lit on count screen without vehicle");
endmodule
`default_nettype wire

// File: sim/lfm_panel_model.sv
/*
  Loop oscillator fault pins and front panel operator.
  Assumes the bench requests levels; they reach pins one edge later.
*/
`timescale 1ns/10ps
`default_nettype none
module lfm_panel_model
(
  input wire logic clk,
  input wire logic [1:0] short_req,
  input wire logic [1:0] open_req,
  input wire logic [4:0] btn_req,
  output var logic [1:0] loop_short = 2'h0,
  output var logic [1:0] loop_open = 2'h0,
  output var logic [4:0] btn = 5'h00
);
  always @(posedge clk)
  begin
    loop_short <= short_req;
    loop_open <= open_req;
  end
  // operator presses, held long enough for the synchronisers
  always @(posedge clk)
    btn <= btn_req;
endmodule
`default_nettype wire

// File: sim/tb_lfm_top.sv
/*
  Bench for the loop fail block over its Avalon slave.
  Assumes the panel model drives fault pins and buttons.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lfm_defs.vh"
module tb_lfm_top;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic rd = 1'h0, wr = 1'h0, disp = 1'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] sh_req = 2'h0, op_req = 2'h0, veh = 2'h0, tim = 2'h0, dcall = 2'h0;
  logic [4:0] btn_req = 5'h00;
  wire [31:0] rdata;
  wire waitreq, seg_blank, all_on, text_on;
  wire [1:0] l_short, l_open, call, led, msg, code0, code1;
  wire [4:0] btn;
  wire [7:0] bar;
  wire [16:0] seg_val;
  wire [2:0] seg_sel, screen;
  integer mismatches = 0, n_checks = 0, cyc = 0, i;
  lfm_top DUT (.MCLK(mclk), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .LOOP_SHORT(l_short), .LOOP_OPEN(l_open), .VEHICLE(veh), .TIMING(tim),
    .DETECT_CALL(dcall), .MAN_RESET_0(btn[3]), .MAN_RESET_1(btn[4]), .BTN_UP(btn[0]),
    .BTN_DOWN(btn[1]), .FUNCTION_STEP_BUTTON(btn[2]), .DISP_CH(disp), .CALL_OUT(call),
    .LED(led), .LOOP_FAIL_MSG(msg), .FAULT_CODE_0(code0), .FAULT_CODE_1(code1),
    .BARGRAPH(bar), .SEG_VALUE(seg_val), .SEG_SEL(seg_sel), .SEG_BLANK(seg_blank),
    .SEG_ALL_ON(all_on), .TEXT_ALL_ON(text_on), .SCREEN(screen));
  lfm_panel_model u_panel (.clk(mclk), .short_req(sh_req), .open_req(op_req),
    .btn_req(btn_req), .loop_short(l_short), .loop_open(l_open), .btn(btn));
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Generous ceiling; the sequence needs about 3.8k cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    while (waitreq !== 1'b0) @(posedge mclk);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, `LFM_REG_STAT, 32'h0);
    chk(rdat & m, e);
  endtask
  task automatic samp(input logic ch, input logic [15:0] chg, input logic [15:0] stp);
    bus(1'b1, ch ? `LFM_REG_MEAS1 : `LFM_REG_MEAS0, {chg, stp});
    tick(4);
  endtask
  task automatic press(input int b);
    btn_req[b] <= 1'b1;
    tick(4);
    btn_req[b] <= 1'b0;
    tick(4);
  endtask
  initial
  begin
    tick(12);
    arst_n <= 1'b1;
    stat(32'hFFFFFFFF, 32'h0);
    bus(1'b0, `LFM_REG_CTRL, 32'h0);
    chk(rdat, `LFM_CTRL_RST);
    bus(1'b0, 4'h1, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, `LFM_REG_STAT, 32'hFFFFFFFF);
    stat(32'hFFFFFFFF, 32'h0);
    $display("Test reset and bus done");
    samp(1'b0, 16'h0000, 16'hF63C);
    chk(msg, 2'h0);
    samp(1'b0, 16'h0000, 16'hF63B);
    chk({msg, code0, call, seg_sel}, {2'h1, `LFM_CODE_LOW, 2'h1, 3'h4});
    stat(32'h00FF0033, 32'h00010011);
    samp(1'b0, 16'h0000, 16'h0000);
    chk({msg, code0, call}, 6'h00);
    stat(32'h00000030, 32'h00000010);
    bus(1'b1, `LFM_REG_CTRL, 32'h00000020);
    samp(1'b1, 16'h0000, 16'h09C5);
    chk({code1, call}, {`LFM_CODE_HIGH, 2'h2});
    samp(1'b1, 16'h0000, 16'h0000);
    sh_req <= 2'h1;
    op_req <= 2'h2;
    tick(8);
    chk({code0, code1, msg}, {`LFM_CODE_LOW, `LFM_CODE_HIGH, 2'h3});
    sh_req <= 2'h0;
    op_req <= 2'h0;
    tick(8);
    samp(1'b0, 16'h0000, 16'h0000);
    samp(1'b1, 16'h0000, 16'h0000);
    chk(msg, 2'h0);
    bus(1'b1, `LFM_REG_CTRL, 32'h00005530);
    stat(32'hFFFF0030, 32'h02020030);
    $display("Test faults done");
    for (i = 0; i < 4; i++)
      press(2);
    stat(32'h000001C0, 32'h00000100);
    press(0);
    stat(32'hFFFF0030, 32'h02000020);
    disp <= 1'b1;
    press(1);
    stat(32'hFFFF0030, 32'h0);
    for (i = 0; i < 256; i++)
    begin
      samp(1'b0, 16'h0000, 16'hF63B);
      samp(1'b0, 16'h0000, 16'h0000);
    end
    stat(32'h00FF0000, 32'h00FF0000);
    press(3);
    stat(32'h00FF0010, 32'h0);
    disp <= 1'b0;
    press(2);
    stat(32'h000001C0, 32'h0);
    $display("Test count clear done");
    dcall <= 2'h1;
    bus(1'b1, `LFM_REG_CTRL, {16'h0000, 13'h0000, `LFM_SCR_TEST});
    tick(4);
    chk({all_on, text_on, bar, call, led}, {10'h3FF, 2'h1, 2'h1});
    dcall <= 2'h0;
    veh <= 2'h1;
    bus(1'b1, `LFM_REG_CTRL, 32'h00000400);
    samp(1'b0, 16'hFFDF, 16'h0000);
    chk(bar, 8'h07);
    samp(1'b0, 16'hFFE1, 16'h0000);
    chk({bar, call}, {8'h03, 2'h0});
    bus(1'b1, `LFM_REG_CTRL, 32'h00000409);
    tick(4);
    chk({seg_sel, bar, seg_val}, {3'h1, 8'h00, 17'h0001F});
    tim <= 2'h1;
    tick(6);
    chk({seg_sel, bar}, {3'h0, 8'h03});
    bus(1'b1, `LFM_REG_CTRL, 32'h29620402);
    tick(4);
    chk({seg_sel, bar, seg_val, seg_blank}, {3'h2, 8'h03, 17'h000BC, 1'b0});
    veh <= 2'h0;
    tick(8);
    chk({seg_sel, bar}, {3'h2, 8'h00});
    samp(1'b1, 16'h0000, 16'h09C5);
    stat(32'hFF000003, 32'h01000002);
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    stat(32'hFFFFFFFF, 32'h0);
    chk({msg, call, code1}, 6'h00);
    $display("Test display done");
    tally_and_finish;
  end
endmodule
bind lfm_top lfm_asserts u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .LOOP_SHORT(LOOP_SHORT),
  .LOOP_OPEN(LOOP_OPEN), .VEHICLE(VEHICLE), .DETECT_CALL(DETECT_CALL), .CALL_OUT(CALL_OUT),
  .LOOP_FAIL_MSG(LOOP_FAIL_MSG), .FAULT_CODE_0(FAULT_CODE_0), .FAULT_CODE_1(FAULT_CODE_1),
  .BARGRAPH(BARGRAPH), .SEG_SEL(SEG_SEL), .SEG_ALL_ON(SEG_ALL_ON), .TEXT_ALL_ON(TEXT_ALL_ON),
  .SCREEN(SCREEN));
`default_nettype wire
